// ==== hdl/i2cm_defines.svh ====
`ifndef I2CM_DEFINES_SVH
`define I2CM_DEFINES_SVH

// ============================================================
// register map (word index = byte offset / 4)
`define I2CM_NREG           5
`define I2CM_IDX_CTRL       3'h0
`define I2CM_IDX_STAT       3'h1
`define I2CM_IDX_ADDR       3'h2
`define I2CM_IDX_TXB        3'h3
`define I2CM_IDX_RXB        3'h4
`define I2CM_OFS_CTRL       32'h0000_0000
`define I2CM_OFS_STAT       32'h0000_0004
`define I2CM_OFS_ADDR       32'h0000_0008
`define I2CM_OFS_TXB        32'h0000_000C
`define I2CM_OFS_RXB        32'h0000_0010

// ============================================================
// field positions
`define I2CM_CTRL_GO        0
`define I2CM_CTRL_READ      1
`define I2CM_CTRL_START     2
`define I2CM_CTRL_STOP      3
`define I2CM_STAT_BUSY      0
`define I2CM_STAT_NACK      1

// ============================================================
// reset values
`define I2CM_RST_WORD       32'h0000_0000
`define I2CM_RST_CTRL       32'h0000_000C

// ============================================================
// timing: link clock cycles per quarter of an scl period
`define I2CM_QTR_CYC        8'h19

`endif

// ==== hdl/i2cm_fifo2.sv ====
`timescale 1ns/10ps

// ============================================================
// two-entry result buffer, flip-flop storage
module i2cm_fifo2
    import i2cm_pkg::*;
(
    input  wire logic  clk,     // system clock
    input  wire logic  arst_n,  // async reset, active low
    i2cm_fifo_if.store fq       // fill and drain handshakes
);

    i2cm_fifo_state_type s_r;
    i2cm_fifo_state_type s_nxt;
    logic                push;
    logic                pop;

    assign fq.in_ready  = (s_r.count != 2'h2);
    assign fq.out_valid = (s_r.count != 2'h0);
    assign fq.out_data  = s_r.mem[s_r.rptr];
    assign push         = fq.in_valid && fq.in_ready;
    assign pop          = fq.out_valid && fq.out_ready;

    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.mem[s_r.wptr] = fq.in_data;
            s_nxt.wptr          = ~s_r.wptr;
        end
        if (pop)
        begin
            s_nxt.rptr = ~s_r.rptr;
        end
        case ({push, pop})
            2'b10:   s_nxt.count = s_r.count + 2'h1;
            2'b01:   s_nxt.count = s_r.count - 2'h1;
            default: s_nxt.count = s_r.count;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule // i2cm_fifo2

// ==== hdl/i2cm_fifo_if.sv ====
`timescale 1ns/10ps

interface i2cm_fifo_if;
    logic       in_valid;
    logic       in_ready;
    logic [8:0] in_data;
    logic       out_valid;
    logic       out_ready;
    logic [8:0] out_data;

    modport store (
        input  in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data
    );
    modport user (
        output in_valid, in_data, out_ready,
        input  in_ready, out_valid, out_data
    );
endinterface

// ==== hdl/i2cm_pkg.sv ====
package i2cm_pkg;

`include "i2cm_defines.svh"

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_START  = 4'h1,
        ST_ADDR   = 4'h2,
        ST_ACK_A  = 4'h3,
        ST_DATA_W = 4'h4,
        ST_ACK_W  = 4'h5,
        ST_DATA_R = 4'h6,
        ST_ACK_M  = 4'h7,
        ST_STOP   = 4'h8,
        ST_DONE   = 4'h9
    } i2cm_state_type;

    typedef struct packed {
        logic [`I2CM_NREG-1:0][31:0] regs;
        logic                        req_tog;
        logic                        done_s1;
        logic                        done_s2;
        logic                        done_s3;
        logic                        pend;
        logic                        ack;
        logic [31:0]                 rdat;
    } i2cm_bus_state_type;

    typedef struct packed {
        logic           req_s1;
        logic           req_s2;
        logic           req_s3;
        logic           sda_s1;
        logic           sda_s2;
        i2cm_state_type state;
        logic [7:0]     qcnt;
        logic [1:0]     phase;
        logic [2:0]     bitn;
        logic [7:0]     shreg;
        logic           rd;
        logic           gen_stop;
        logic [7:0]     txb;
        logic           nack;
        logic [7:0]     rxb;
        logic           done_tog;
        logic           scl_low;
        logic           sda_low;
    } i2cm_link_state_type;

    typedef struct packed {
        logic [1:0][8:0] mem;
        logic            wptr;
        logic            rptr;
        logic [1:0]      count;
    } i2cm_fifo_state_type;

endpackage

// ==== hdl/i2cm_top.sv ====
`timescale 1ns/10ps
`include "i2cm_defines.svh"

module i2cm_top
    import i2cm_pkg::*;
(
    input  wire logic        clk,       // system clock, bus side
    input  wire logic        arst_n,    // async reset, active low
    input  wire logic        link_clk,  // clock of the i2c engine
    input  wire logic        wb_cyc_i,  // wishbone cycle
    input  wire logic        wb_stb_i,  // wishbone strobe
    input  wire logic        wb_we_i,   // wishbone write enable
    input  wire logic [31:0] wb_adr_i,  // wishbone byte address
    input  wire logic [3:0]  wb_sel_i,  // wishbone byte lane selects
    input  wire logic [31:0] wb_dat_i,  // wishbone write data
    output logic      [31:0] wb_dat_o,  // wishbone read data
    output logic             wb_ack_o,  // wishbone acknowledge
    input  wire logic        scl_i,     // scl pin level
    output logic             scl_o,     // scl drive value, always low
    output logic             scl_oe,    // scl pulled low when high
    input  wire logic        sda_i,     // sda pin level
    output logic             sda_o,     // sda drive value, always low
    output logic             sda_oe     // sda pulled low when high
);

    // ============================================================
    // helpers
    function automatic logic [3:0] reg_decode(input logic [31:0] adr);
        logic [2:0] idx;
        logic       hit;
        idx = adr[4:2];
        hit = (adr[31:5] == 27'h0) && (adr[1:0] == 2'h0)
              && (idx < 3'(`I2CM_NREG));
        return {hit, idx};
    endfunction

    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] dat,
                                               input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                res[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ============================================================
    // bus side state
    i2cm_bus_state_type  b_r;
    i2cm_bus_state_type  b_nxt;
    i2cm_link_state_type l_r;
    i2cm_link_state_type l_nxt;
    i2cm_fifo_if         fq ();

    logic [3:0]  dec;
    logic        bus_req;
    logic        bus_wr;
    logic        busy;
    logic [31:0] ctrl_w;
    logic [31:0] wr_word;
    logic        done_evt;

    assign dec      = reg_decode(wb_adr_i);
    assign bus_req  = wb_cyc_i && wb_stb_i && !b_r.ack;
    assign bus_wr   = bus_req && wb_we_i && dec[3];
    assign busy     = b_r.regs[`I2CM_IDX_STAT][`I2CM_STAT_BUSY];
    assign ctrl_w   = b_r.regs[`I2CM_IDX_CTRL];
    assign wr_word  = lane_merge(b_r.regs[dec[2:0]], wb_dat_i, wb_sel_i);
    assign done_evt = b_r.done_s2 ^ b_r.done_s3;

    // result from the link domain is held stable until the next request
    assign fq.in_valid  = done_evt || b_r.pend;
    assign fq.in_data   = {l_r.nack, l_r.rxb};
    // private port yields to a bus write in the same cycle
    assign fq.out_ready = !bus_wr;

    i2cm_fifo2 u_fifo (
        .clk    (clk),
        .arst_n (arst_n),
        .fq     (fq.store)
    );

    always_comb
    begin
        b_nxt         = b_r;
        b_nxt.done_s1 = l_r.done_tog;
        b_nxt.done_s2 = b_r.done_s1;
        b_nxt.done_s3 = b_r.done_s2;
        b_nxt.ack     = bus_req;
        if (done_evt && !fq.in_ready)
        begin
            b_nxt.pend = 1'b1;
        end
        else if (fq.in_ready)
        begin
            b_nxt.pend = 1'b0;
        end
        // reads answer zero on an unmapped address
        if (bus_req && !wb_we_i && dec[3])
        begin
            b_nxt.rdat = b_r.regs[dec[2:0]];
        end
        else
        begin
            b_nxt.rdat = 32'h0;
        end
        // status and receive byte are read-only; the others are
        // frozen while busy so the link sees stable command words
        if (bus_wr && !busy)
        begin
            case (dec[2:0])
                `I2CM_IDX_CTRL:
                begin
                    b_nxt.regs[`I2CM_IDX_CTRL] = wr_word & 32'h0000_000E;
                    if (wb_sel_i[0] && wb_dat_i[`I2CM_CTRL_GO])
                    begin
                        b_nxt.regs[`I2CM_IDX_STAT][`I2CM_STAT_BUSY] = 1'b1;
                        b_nxt.regs[`I2CM_IDX_STAT][`I2CM_STAT_NACK] = 1'b0;
                        b_nxt.req_tog = ~b_r.req_tog;
                    end
                end
                `I2CM_IDX_ADDR:
                begin
                    b_nxt.regs[`I2CM_IDX_ADDR] = wr_word & 32'h0000_007F;
                end
                `I2CM_IDX_TXB:
                begin
                    b_nxt.regs[`I2CM_IDX_TXB] = wr_word & 32'h0000_00FF;
                end
                default:
                begin
                    b_nxt.regs = b_r.regs;
                end
            endcase
        end
        // private port: engine result lands in the register store
        if (fq.out_valid && fq.out_ready)
        begin
            b_nxt.regs[`I2CM_IDX_STAT][`I2CM_STAT_BUSY] = 1'b0;
            b_nxt.regs[`I2CM_IDX_STAT][`I2CM_STAT_NACK] = fq.out_data[8];
            if (ctrl_w[`I2CM_CTRL_READ])
            begin
                b_nxt.regs[`I2CM_IDX_RXB] = {24'h0, fq.out_data[7:0]};
            end
        end
    end

    // all bus side state on the shared system clock
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            b_r                        <= '0;
            b_r.regs[`I2CM_IDX_CTRL]   <= `I2CM_RST_CTRL;
            b_r.regs[`I2CM_IDX_STAT]   <= `I2CM_RST_WORD;
        end
        else
        begin
            b_r <= b_nxt;
        end
    end

    assign wb_dat_o = b_r.rdat;
    assign wb_ack_o = b_r.ack;

    // ============================================================
    // link side engine
    logic req_evt;
    logic tick;
    logic last_bit;

    assign req_evt  = l_r.req_s2 ^ l_r.req_s3;
    assign tick     = (l_r.qcnt == `I2CM_QTR_CYC - 8'h1);
    assign last_bit = (l_r.bitn == 3'h0);

    always_comb
    begin
        l_nxt        = l_r;
        l_nxt.req_s1 = b_r.req_tog;
        l_nxt.req_s2 = l_r.req_s1;
        l_nxt.req_s3 = l_r.req_s2;
        l_nxt.sda_s1 = sda_i;
        l_nxt.sda_s2 = l_r.sda_s1;
        if (l_r.state == ST_IDLE || tick)
        begin
            l_nxt.qcnt = 8'h0;
        end
        else
        begin
            l_nxt.qcnt = l_r.qcnt + 8'h1;
        end
        if (tick)
        begin
            l_nxt.phase = l_r.phase + 2'h1;
        end
        case (l_r.state)
            ST_IDLE:
            begin
                l_nxt.phase = 2'h0;
                // command words are stable: the bus side froze them at go
                if (req_evt)
                begin
                    l_nxt.rd       = ctrl_w[`I2CM_CTRL_READ];
                    l_nxt.gen_stop = ctrl_w[`I2CM_CTRL_STOP];
                    l_nxt.txb      = b_r.regs[`I2CM_IDX_TXB][7:0];
                    l_nxt.shreg    = {b_r.regs[`I2CM_IDX_ADDR][6:0],
                                      ctrl_w[`I2CM_CTRL_READ]};
                    l_nxt.bitn     = 3'h7;
                    l_nxt.nack     = 1'b0;
                    // without START the previous transfer must have left scl low
                    l_nxt.state    = ctrl_w[`I2CM_CTRL_START] ? ST_START : ST_ADDR;
                end
            end
            ST_START:
            begin
                if (tick)
                begin
                    case (l_r.phase)
                        2'h0:    l_nxt.sda_low = 1'b0;
                        2'h1:    l_nxt.scl_low = 1'b0;
                        2'h2:    l_nxt.sda_low = 1'b1;
                        default:
                        begin
                            l_nxt.scl_low = 1'b1;
                            l_nxt.state   = ST_ADDR;
                        end
                    endcase
                end
            end
            ST_ADDR, ST_DATA_W, ST_DATA_R:
            begin
                if (tick)
                begin
                    case (l_r.phase)
                        2'h0:    l_nxt.sda_low = (l_r.state == ST_DATA_R) ? 1'b0 : !l_r.shreg[7];
                        2'h1:    l_nxt.scl_low = 1'b0;
                        2'h2:
                        begin
                            if (l_r.state == ST_DATA_R)
                            begin
                                l_nxt.shreg = {l_r.shreg[6:0], l_r.sda_s2};
                            end
                        end
                        default:
                        begin
                            l_nxt.scl_low = 1'b1;
                            l_nxt.bitn    = l_r.bitn - 3'h1;
                            if (l_r.state != ST_DATA_R)
                            begin
                                l_nxt.shreg = {l_r.shreg[6:0], 1'b0};
                            end
                            if (last_bit)
                            begin
                                case (l_r.state)
                                    ST_ADDR:   l_nxt.state = ST_ACK_A;
                                    ST_DATA_W: l_nxt.state = ST_ACK_W;
                                    default:   l_nxt.state = ST_ACK_M;
                                endcase
                            end
                        end
                    endcase
                end
            end
            ST_ACK_A, ST_ACK_W, ST_ACK_M:
            begin
                if (tick)
                begin
                    case (l_r.phase)
                        // single-byte read: master answers with nack
                        2'h0:    l_nxt.sda_low = 1'b0;
                        2'h1:    l_nxt.scl_low = 1'b0;
                        2'h2:
                        begin
                            if (l_r.state != ST_ACK_M)
                            begin
                                l_nxt.nack = l_r.sda_s2;
                            end
                        end
                        default:
                        begin
                            l_nxt.scl_low = 1'b1;
                            l_nxt.bitn    = 3'h7;
                            if (l_r.state == ST_ACK_M)
                            begin
                                l_nxt.rxb = l_r.shreg;
                            end
                            if (l_r.state == ST_ACK_A && !l_nxt.nack)
                            begin
                                l_nxt.shreg = l_r.txb;
                                l_nxt.state = l_r.rd ? ST_DATA_R : ST_DATA_W;
                            end
                            else
                            begin
                                l_nxt.state = l_r.gen_stop ? ST_STOP : ST_DONE;
                            end
                        end
                    endcase
                end
            end
            ST_STOP:
            begin
                if (tick)
                begin
                    case (l_r.phase)
                        2'h0:    l_nxt.sda_low = 1'b1;
                        2'h1:    l_nxt.scl_low = 1'b0;
                        2'h2:    l_nxt.sda_low = 1'b0;
                        default: l_nxt.state   = ST_DONE;
                    endcase
                end
            end
            ST_DONE:
            begin
                l_nxt.done_tog = ~l_r.done_tog;
                l_nxt.state    = ST_IDLE;
            end
            default:
            begin
                l_nxt.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            l_r        <= '0;
            l_r.sda_s1 <= 1'b1;
            l_r.sda_s2 <= 1'b1;
            l_r.state  <= ST_IDLE;
        end
        else
        begin
            l_r <= l_nxt;
        end
    end

    // open drain: only ever pull low, never drive high
    assign scl_o  = 1'b0;
    assign sda_o  = 1'b0;
    assign scl_oe = l_r.scl_low;
    assign sda_oe = l_r.sda_low;

endmodule // i2cm_top

// ==== testbench/i2cm_slave_model.sv ====
`timescale 1ns/10ps

// ============================================================
// behavioural i2c slave, no clock stretching
module i2cm_slave_model #(
    parameter logic [6:0] SLV_ADDR = 7'h2A
) (
    input  wire logic       scl,      // scl wire
    input  wire logic       sda,      // sda wire
    input  wire logic [7:0] tx_byte,  // byte served on reads
    output logic            sda_low,  // pulls sda low
    output logic [7:0]      got_addr, // last address byte
    output logic [7:0]      got_data, // last written byte
    output logic [7:0]      n_start,  // starts seen
    output logic [7:0]      n_stop    // stops seen
);
    logic [7:0] sh;

    task automatic get_byte();
        for (int i = 0; i < 8; i++)
        begin
            @(posedge scl);
            sh = {sh[6:0], sda};
        end
    endtask

    always @(negedge sda)
        if (scl === 1'h1)
            n_start = n_start + 8'h01;
    always @(posedge sda)
        if (scl === 1'h1)
            n_stop = n_stop + 8'h01;

    initial
    begin
        sda_low = 1'h0;
        n_start = 8'h00;
        n_stop = 8'h00;
        forever
        begin
            @(negedge sda iff scl === 1'h1);
            get_byte();
            got_addr = sh;
            if (sh[7:1] == SLV_ADDR)
            begin
                @(negedge scl);
                sda_low = 1'h1;
                if (sh[0])
                    for (int i = 7; i >= 0; i--)
                    begin
                        @(negedge scl);
                        sda_low = !tx_byte[i];
                    end
                else
                begin
                    @(negedge scl);
                    sda_low = 1'h0;
                    get_byte();
                    got_data = sh;
                    @(negedge scl);
                    sda_low = 1'h1;
                end
                @(negedge scl);
                sda_low = 1'h0;
            end
        end
    end
endmodule // i2cm_slave_model

// ==== testbench/i2cm_top_sva.sv ====
`timescale 1ns/10ps

module i2cm_top_sva
    import i2cm_pkg::*;
(
    input wire logic        clk,      // bus clock
    input wire logic        arst_n,   // reset
    input wire logic        link_clk, // link clock
    input wire logic        wb_cyc_i, // cycle
    input wire logic        wb_stb_i, // strobe
    input wire logic        wb_we_i,  // write
    input wire logic [31:0] wb_adr_i, // address
    input wire logic [3:0]  wb_sel_i, // lanes
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic        wb_ack_o, // ack
    input wire logic        scl_i,    // scl level
    input wire logic        scl_o,    // scl value
    input wire logic        scl_oe,   // scl pull
    input wire logic        sda_i,    // sda level
    input wire logic        sda_o,    // sda value
    input wire logic        sda_oe    // sda pull
);
    // one quarter of scl is 25 link cycles; a little slack above that
    localparam int QMAX = 30;

    // ============================================================
    // sequences
    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_read_at(a);
        s_taken ##0 (!wb_we_i && wb_adr_i == a);
    endsequence
    sequence s_start;
        !scl_oe && $rose(sda_oe);
    endsequence

    // ============================================================
    // bus side
    property p_ack_next;
        @(posedge clk) disable iff (!arst_n) s_taken |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("request not answered next cycle");
    property p_ack_single;
        @(posedge clk) disable iff (!arst_n) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single)
        else $error("ack longer than one cycle");
    property p_dat_idle;
        @(posedge clk) disable iff (!arst_n) !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data outside ack");
    property p_go_zero;
        @(posedge clk) disable iff (!arst_n) s_read_at(32'h0) |=> !wb_dat_o[0];
    endproperty
    a_go_zero: assert property (p_go_zero)
        else $error("go bit reads back set");
    property p_unmapped;
        @(posedge clk) disable iff (!arst_n)
            s_taken ##0 (!wb_we_i && wb_adr_i > 32'h10) |=> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    // ============================================================
    // link side
    property p_open_drain;
        @(posedge link_clk) disable iff (!arst_n) !scl_o && !sda_o;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("pin driven high");
    property p_start_shape;
        @(posedge link_clk) disable iff (!arst_n)
            s_start |-> (!scl_oe) [*3] ##[1:QMAX] scl_oe;
    endproperty
    a_start_shape: assert property (p_start_shape)
        else $error("start not followed by scl low");
    property p_scl_high;
        @(posedge link_clk) disable iff (!arst_n) $fell(scl_oe) |-> (!scl_oe) [*8];
    endproperty
    a_scl_high: assert property (p_scl_high)
        else $error("scl high phase too short");
endmodule // i2cm_top_sva

bind i2cm_top i2cm_top_sva i2cm_top_sva_inst (
    .clk(clk), .arst_n(arst_n), .link_clk(link_clk),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe)
);

// ==== testbench/i2cm_top_tb.sv ====
`timescale 1ns/10ps
`include "i2cm_defines.svh"

`define TB_CHK(what, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            fails++; \
            $display("mismatch %s expected %h seen %h", what, e, g); \
        end \
    end

module i2cm_top_tb;
    import i2cm_pkg::*;
    localparam logic [6:0] SLV = 7'h2A;
    logic        clk, arst_n, link_clk, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, lfsr_r;
    logic [3:0]  wb_sel_i;
    logic        scl_o, scl_oe, sda_o, sda_oe, sda_low;
    logic [7:0]  tx_byte, got_addr, got_data, n_start, n_stop;
    logic [31:0] mdl [5];
    int          fails, n_compared;
    // open drain with pull-ups
    wire         scl_w = !scl_oe;
    wire         sda_w = !(sda_oe || sda_low);

    i2cm_top i2cm_top_inst (
        .clk(clk), .arst_n(arst_n), .link_clk(link_clk), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
    i2cm_slave_model #(.SLV_ADDR(SLV)) i2cm_slave_model_inst (
        .scl(scl_w), .sda(sda_w), .tx_byte(tx_byte), .sda_low(sda_low),
        .got_addr(got_addr), .got_data(got_data), .n_start(n_start), .n_stop(n_stop));

    always #2.5 clk = ~clk;
    initial
    begin
        link_clk = 1'h0;
        #13.1;
        forever #40 link_clk = ~link_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                           output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack_o !== 1'h1 && n < 8);
        if (wb_ack_o !== 1'h1)
            fails++;
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask

    // the model ignores writes while busy, as the block must
    task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        wb_xfer(1'h1, adr, dat, q);
        if (adr[1:0] == 2'h0 && adr <= 32'h10 && mdl[1][0] !== 1'h1)
        begin
            if (adr[4:2] == 3'h0)
                mdl[0] = dat & 32'h0000_000E;
            if (adr[4:2] == 3'h2 || adr[4:2] == 3'h3)
                mdl[adr[4:2]] = dat;
            if (adr[4:2] == 3'h0 && dat[0])
                mdl[1] = 32'h0000_0001;
        end
    endtask

    task automatic rd_chk(input logic [31:0] adr, input string what);
        logic [31:0] q;
        logic [31:0] e;
        wb_xfer(1'h0, adr, 32'h0, q);
        e = (adr[1:0] == 2'h0 && adr <= 32'h10) ? mdl[adr[4:2]] : 32'h0;
        `TB_CHK(what, e, q)
    endtask

    task automatic run_xfer(input logic [3:0] ctl, input logic [6:0] a, input logic nk);
        logic [7:0]  st0;
        logic [7:0]  sp0;
        logic [31:0] q;
        int          n;
        lfsr_r = lfsr_next(lfsr_r);
        tx_byte <= lfsr_r[7:0];
        wr(`I2CM_OFS_ADDR, {25'h0, a});
        wr(`I2CM_OFS_TXB, {24'h0, lfsr_r[15:8]});
        st0 = n_start;
        sp0 = n_stop;
        wr(`I2CM_OFS_CTRL, {28'h0, ctl});
        rd_chk(`I2CM_OFS_STAT, "busy");
        wr(`I2CM_OFS_TXB, 32'h0000_00A5);
        rd_chk(`I2CM_OFS_TXB, "txb while busy");
        n = 0;
        do
        begin
            wb_xfer(1'h0, `I2CM_OFS_STAT, 32'h0, q);
            n++;
        end
        while (q[0] !== 1'h0 && n < 20000);
        if (q[0] !== 1'h0)
            fails++;
        mdl[1] = {30'h0, nk, 1'h0};
        if (ctl[1] && !nk)
            mdl[4] = {24'h0, lfsr_r[7:0]};
        rd_chk(`I2CM_OFS_STAT, "status");
        rd_chk(`I2CM_OFS_RXB, "rx byte");
        `TB_CHK("addr byte", {a, ctl[1]}, got_addr)
        if (!ctl[1] && !nk)
            `TB_CHK("data byte", lfsr_r[15:8], got_data)
        `TB_CHK("starts", st0 + {7'h0, ctl[2]}, n_start)
        `TB_CHK("stops", sp0 + {7'h0, ctl[3]}, n_stop)
    endtask

    initial
    begin
        repeat (110000) @(posedge clk);
        fails++;
        wrap_up();
    end

    initial
    begin
        clk = 1'h0;
        arst_n <= 1'h0;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        {wb_adr_i, wb_dat_i} = 64'h0;
        wb_sel_i = 4'hF;
        tx_byte = 8'h00;
        fails = 0;
        n_compared = 0;
        lfsr_r = 32'hCBD0DDB4;
        mdl = '{32'h0000_000C, 32'h0, 32'h0, 32'h0, 32'h0};
        repeat (6) @(posedge clk);
        arst_n <= 1'h1;
        for (int i = 0; i < 6; i++)
            rd_chk(32'(i * 4), "reset value");
        lfsr_r = lfsr_next(lfsr_r);
        wr(`I2CM_OFS_ADDR, {25'h0, lfsr_r[6:0]});
        wr(`I2CM_OFS_TXB, {24'h0, lfsr_r[15:8]});
        wr(`I2CM_OFS_CTRL, 32'h0000_0006);
        wr(`I2CM_OFS_STAT, 32'hFFFF_FFFF);
        wr(`I2CM_OFS_RXB, 32'hFFFF_FFFF);
        wr(32'h0000_0018, 32'hFFFF_FFFF);
        for (int i = 0; i < 7; i++)
            rd_chk(32'(i * 4), "readback");
        run_xfer(4'hD, SLV, 1'h0);
        // read without stop leaves scl low, so the next one may skip start
        run_xfer(4'h7, SLV, 1'h0);
        // no start: the slave stays deaf and the address is not answered
        run_xfer(4'hB, SLV, 1'h1);
        wrap_up();
    end
endmodule // i2cm_top_tb
